/* File: design/timer8_waveform.sv */
// Purpose: counter, flags and compare output of an 8-bit waveform timer
// Assumes: software strobes are one-cycle pulses synchronous to i_clk_sys
// Notes: all outputs registered; count write has priority over counting
`timescale 1ns/1ps

module timer8_waveform import timer8_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [1:0] i_waveform_mode_select,
	input wire logic [1:0] i_compare_output_action,
	input wire logic [2:0] i_clock_prescale_select,
	input wire logic i_count_write,
	input wire logic [7:0] i_count_wdata,
	input wire logic i_compare_write,
	input wire logic [7:0] i_compare_wdata,
	input wire logic i_overflow_clear,
	input wire logic i_compare_flag_clear,
	output logic [7:0] o_count_value,
	output logic [7:0] o_compare_value,
	output logic o_overflow_flag,
	output logic o_compare_match_flag,
	output logic o_compare_output
);

	waveform_mode_t mode;
	output_action_t action;
	logic tick;

	logic [7:0] count_value;
	logic [7:0] next_count_value;
	direction_t direction;
	direction_t next_direction;
	logic match_block;
	logic next_match_block;

	logic [7:0] compare_value;
	logic [7:0] next_compare_value;
	logic [7:0] compare_buffer;
	logic [7:0] next_compare_buffer;

	logic overflow_flag;
	logic next_overflow_flag;
	logic compare_match_flag;
	logic next_compare_match_flag;
	logic match_pending;
	logic next_match_pending;
	logic compare_output;
	logic next_compare_output;

	logic pwm_mode;
	logic at_max;
	logic at_bottom;
	logic match;
	logic overflow_event;

	assign mode = waveform_mode_t'(i_waveform_mode_select);
	assign action = output_action_t'(i_compare_output_action);

	timer8_prescaler prescaler (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_clock_prescale_select(i_clock_prescale_select),
		.o_tick(tick)
	);

	// counter unit
	always_comb begin
		pwm_mode = (mode == MODE_FAST_PWM) || (mode == MODE_PHASE_PWM);
		at_max = (count_value == COUNT_MAX);
		at_bottom = (count_value == COUNT_BOTTOM);
		match = (count_value == compare_value) && !match_block;
		next_count_value = count_value;
		next_direction = direction;
		next_match_block = match_block;
		if (i_count_write) begin
			next_count_value = i_count_wdata;
			next_match_block = 1'b1;
		end else if (tick) begin
			next_match_block = 1'b0;
			unique case (mode)
				MODE_NORMAL: begin
					next_count_value = count_value + COUNT_STEP;
					next_direction = DIR_UP;
				end
				MODE_CLEAR_ON_COMPARE: begin
					next_direction = DIR_UP;
					if (match) begin
						next_count_value = COUNT_BOTTOM;
					end else begin
						next_count_value = count_value + COUNT_STEP;
					end
				end
				MODE_FAST_PWM: begin
					next_direction = DIR_UP;
					if (at_max) begin
						next_count_value = COUNT_BOTTOM;
					end else begin
						next_count_value = count_value + COUNT_STEP;
					end
				end
				MODE_PHASE_PWM: begin
					// turn-around points each held one tick: 510-tick period
					if (at_max) begin
						next_direction = DIR_DOWN;
						next_count_value = count_value - COUNT_STEP;
					end else if (at_bottom) begin
						next_direction = DIR_UP;
						next_count_value = count_value + COUNT_STEP;
					end else if (direction == DIR_UP) begin
						next_count_value = count_value + COUNT_STEP;
					end else begin
						next_count_value = count_value - COUNT_STEP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			count_value <= COUNT_BOTTOM;
			direction <= DIR_UP;
			match_block <= 1'b0;
		end else begin
			count_value <= next_count_value;
			direction <= next_direction;
			match_block <= next_match_block;
		end
	end

	// compare value, direct or double buffered
	always_comb begin
		next_compare_buffer = compare_buffer;
		next_compare_value = compare_value;
		if (i_compare_write) begin
			next_compare_buffer = i_compare_wdata;
		end
		if (!pwm_mode) begin
			if (i_compare_write) begin
				next_compare_value = i_compare_wdata;
			end
		end else if (tick && !i_count_write && at_max) begin
			// fast: just before bottom; phase: at top
			next_compare_value = compare_buffer;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			compare_buffer <= COMPARE_RESET;
			compare_value <= COMPARE_RESET;
		end else begin
			compare_buffer <= next_compare_buffer;
			compare_value <= next_compare_value;
		end
	end

	// flags: hardware set wins over a clear in the same cycle
	always_comb begin
		overflow_event = 1'b0;
		if (tick && !i_count_write) begin
			unique case (mode)
				MODE_NORMAL: overflow_event = at_max;
				// a clear by a match at max also passes max to zero
				MODE_CLEAR_ON_COMPARE: overflow_event = at_max;
				MODE_FAST_PWM: overflow_event = at_max;
				MODE_PHASE_PWM: overflow_event = at_bottom && (direction == DIR_DOWN);
			endcase
		end
		next_overflow_flag = overflow_flag;
		if (i_overflow_clear) begin
			next_overflow_flag = 1'b0;
		end
		if (overflow_event) begin
			next_overflow_flag = 1'b1;
		end
		next_match_pending = match_pending;
		next_compare_match_flag = compare_match_flag;
		if (i_compare_flag_clear) begin
			next_compare_match_flag = 1'b0;
		end
		if (tick) begin
			next_match_pending = match && !i_count_write;
			if (match_pending) begin
				next_compare_match_flag = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			overflow_flag <= 1'b0;
			compare_match_flag <= 1'b0;
			match_pending <= 1'b0;
		end else begin
			overflow_flag <= next_overflow_flag;
			compare_match_flag <= next_compare_match_flag;
			match_pending <= next_match_pending;
		end
	end

	// waveform generator
	always_comb begin
		next_compare_output = compare_output;
		if (tick && !i_count_write) begin
			unique case (mode)
				MODE_NORMAL, MODE_CLEAR_ON_COMPARE: begin
					if (match) begin
						unique case (action)
							ACT_NONE: next_compare_output = compare_output;
							ACT_TOGGLE: next_compare_output = !compare_output;
							ACT_CLEAR: next_compare_output = 1'b0;
							ACT_SET: next_compare_output = 1'b1;
						endcase
					end
				end
				MODE_FAST_PWM: begin
					if (action == ACT_TOGGLE) begin
						if (match) begin
							next_compare_output = !compare_output;
						end
					end else if (action != ACT_NONE) begin
						// bottom action wins so compare at max gives a flat level
						if (at_max) begin
							next_compare_output = (action == ACT_CLEAR);
						end else if (match) begin
							next_compare_output = (action == ACT_SET);
						end
					end
				end
				MODE_PHASE_PWM: begin
					if (action == ACT_CLEAR || action == ACT_SET) begin
						if (at_max) begin
							// compare at max keeps the down-match level
							if (match) begin
								next_compare_output = (action == ACT_CLEAR);
							end else begin
								next_compare_output = (action == ACT_SET);
							end
						end else if (match) begin
							if (direction == DIR_UP || at_bottom) begin
								next_compare_output = (action == ACT_SET);
							end else begin
								next_compare_output = (action == ACT_CLEAR);
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			compare_output <= OUTPUT_RESET;
		end else begin
			compare_output <= next_compare_output;
		end
	end

	assign o_count_value = count_value;
	assign o_compare_value = compare_value;
	assign o_overflow_flag = overflow_flag;
	assign o_compare_match_flag = compare_match_flag;
	assign o_compare_output = compare_output;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	property p_normal_wrap;
		tick && !i_count_write && mode == MODE_NORMAL && at_max |=> count_value == COUNT_BOTTOM && overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow missed");

	property p_overflow_sticky;
		overflow_flag && !i_overflow_clear |=> overflow_flag;
	endproperty
	a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag dropped by itself");

	property p_overflow_clear;
		i_overflow_clear && !tick |=> !overflow_flag;
	endproperty
	a_overflow_clear: assert property (p_overflow_clear) else $error("overflow flag not cleared");

	property p_count_write;
		i_count_write |=> count_value == $past(i_count_wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write not taken");

	property p_ctc_clear;
		tick && !i_count_write && mode == MODE_CLEAR_ON_COMPARE && match |=> count_value == COUNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared on match");

	property p_ctc_toggle;
		tick && !i_count_write && mode == MODE_CLEAR_ON_COMPARE && action == ACT_TOGGLE && match
			|=> compare_output != $past(compare_output);
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("output did not toggle");

	property p_fast_wrap;
		tick && !i_count_write && mode == MODE_FAST_PWM && at_max |=> count_value == COUNT_BOTTOM && overflow_flag;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm wrap wrong");

	property p_phase_turn;
		tick && !i_count_write && mode == MODE_PHASE_PWM && at_max
			|=> count_value == COUNT_MAX - COUNT_STEP && direction == DIR_DOWN;
	endproperty
	a_phase_turn: assert property (p_phase_turn) else $error("phase pwm turn-around wrong");

	property p_flag_after_match;
		tick && match_pending |=> compare_match_flag;
	endproperty
	a_flag_after_match: assert property (p_flag_after_match) else $error("compare flag not set");

	property p_buffer_hold;
		pwm_mode && !(tick && at_max) |=> $stable(compare_value);
	endproperty
	a_buffer_hold: assert property (p_buffer_hold) else $error("buffered compare changed early");

	property p_stopped;
		i_clock_prescale_select == SEL_STOP && !tick && !i_count_write |=> $stable(count_value);
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped counter moved");

endmodule

/* File: design/timer8_pkg.sv */
// Purpose: shared constants and types of the 8-bit waveform timer
// Assumes: single clock domain, timer tick is a clock enable
// Notes: mode and action codes follow the control field encodings
package timer8_pkg;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PHASE_PWM = 2'b01,
		MODE_CLEAR_ON_COMPARE = 2'b10,
		MODE_FAST_PWM = 2'b11
	} waveform_mode_t;

	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR = 2'b10,
		ACT_SET = 2'b11
	} output_action_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} direction_t;

	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_STEP = 8'h01;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic OUTPUT_RESET = 1'b0;

	localparam int PRESCALE_W = 10;
	localparam logic [9:0] PRESCALE_STEP = 10'h001;
	localparam logic [9:0] PRESCALE_RESET = 10'h000;
	localparam logic [2:0] SEL_STOP = 3'h0;
	localparam logic [2:0] SEL_DIV1 = 3'h1;
	localparam logic [2:0] SEL_DIV8 = 3'h2;
	localparam logic [2:0] SEL_DIV32 = 3'h3;
	localparam logic [2:0] SEL_DIV64 = 3'h4;
	localparam logic [2:0] SEL_DIV128 = 3'h5;
	localparam logic [2:0] SEL_DIV256 = 3'h6;
	localparam logic [2:0] SEL_DIV1024 = 3'h7;
	localparam logic [9:0] MASK_DIV1 = 10'h000;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV32 = 10'h01f;
	localparam logic [9:0] MASK_DIV64 = 10'h03f;
	localparam logic [9:0] MASK_DIV128 = 10'h07f;
	localparam logic [9:0] MASK_DIV256 = 10'h0ff;
	localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

endpackage

/* File: design/timer8_prescaler.sv */
// Purpose: timer clock enable from the system clock by a selectable divide
// Assumes: select is steady while counting; changes take effect at once
// Notes: tick is registered; a one-cycle pulse, held high every clock at divide by 1
`timescale 1ns/1ps
module timer8_prescaler import timer8_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [2:0] i_clock_prescale_select,
	output logic o_tick
);

	logic [PRESCALE_W-1:0] div_count;
	logic [PRESCALE_W-1:0] next_div_count;
	logic [PRESCALE_W-1:0] div_mask;
	logic next_tick;

	always_comb begin
		unique case (i_clock_prescale_select)
			SEL_STOP: div_mask = MASK_DIV1;
			SEL_DIV1: div_mask = MASK_DIV1;
			SEL_DIV8: div_mask = MASK_DIV8;
			SEL_DIV32: div_mask = MASK_DIV32;
			SEL_DIV64: div_mask = MASK_DIV64;
			SEL_DIV128: div_mask = MASK_DIV128;
			SEL_DIV256: div_mask = MASK_DIV256;
			SEL_DIV1024: div_mask = MASK_DIV1024;
		endcase
		next_div_count = div_count + PRESCALE_STEP;
		// one tick every mask+1 clocks, none when stopped
		next_tick = (i_clock_prescale_select != SEL_STOP) && ((div_count & div_mask) == div_mask);
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div_count <= PRESCALE_RESET;
			o_tick <= 1'b0;
		end else begin
			div_count <= next_div_count;
			o_tick <= next_tick;
		end
	end

endmodule

/* File: test/pin_load.sv */
// Purpose: load on the compare output pin, measures the waveform it sees
// Assumes: pin sampled on each rising system clock edge
// Notes: period and high time are counted between rising edges
`timescale 1ns/1ps
module pin_load (
	input wire logic i_clk_sys,
	input wire logic i_pin,
	output int o_period,
	output int o_high,
	output int o_edges
);
	int run = 0;
	int hi = 0;
	int period = 0;
	int high = 0;
	int edges = 0;
	logic last = 1'b0;
	assign o_period = period;
	assign o_high = high;
	assign o_edges = edges;
	always @(posedge i_clk_sys) begin
		last <= i_pin;
		run <= run + 1;
		hi <= hi + int'(i_pin);
		if (i_pin === 1'b1 && last === 1'b0) begin
			period <= run;
			high <= hi;
			edges <= edges + 1;
			run <= 1;
			hi <= 1;
		end
	end
endmodule

/* File: test/timer8_waveform_bench.sv */
// Purpose: self-checking bench of the 8-bit waveform timer
// Assumes: inputs change at the falling clock edge
// Notes: pin waveforms are judged by the pin_load model
`timescale 1ns/1ps
module timer8_waveform_bench;
	import timer8_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_nrst = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [1:0] act = 2'h0;
	logic [2:0] sel = 3'h0;
	logic cw = 1'b0, pw = 1'b0, oc = 1'b0, fc = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [7:0] cnt, cmp;
	logic ovf, cmf, pin;
	int period, high, edges, n, e0;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

	timer8_waveform DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_waveform_mode_select(mode),
		.i_compare_output_action(act), .i_clock_prescale_select(sel), .i_count_write(cw),
		.i_count_wdata(wd), .i_compare_write(pw), .i_compare_wdata(wd), .i_overflow_clear(oc),
		.i_compare_flag_clear(fc), .o_count_value(cnt), .o_compare_value(cmp),
		.o_overflow_flag(ovf), .o_compare_match_flag(cmf), .o_compare_output(pin));
	pin_load load (.i_clk_sys(i_clk_sys), .i_pin(pin), .o_period(period), .o_high(high), .o_edges(edges));

	always #10 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic settle(input int k);
		repeat (k) @(negedge i_clk_sys);
	endtask
	task automatic setup(input logic [1:0] m, input logic [1:0] a, input logic [2:0] s);
		@(negedge i_clk_sys);
		mode = m;
		act = a;
		sel = s;
	endtask
	// 0 count write, 1 compare write, 2 overflow clear, 3 compare flag clear
	task automatic strobe(input int which, input logic [7:0] v);
		@(negedge i_clk_sys);
		wd = v;
		cw = (which == 0);
		pw = (which == 1);
		oc = (which == 2);
		fc = (which == 3);
		@(negedge i_clk_sys);
		{cw, pw, oc, fc} = 4'h0;
	endtask
	task automatic wait_count(input logic [7:0] v);
		n = 0;
		while (cnt !== v && n < 3000) begin
			@(negedge i_clk_sys);
			n++;
		end
		chk("count reached", v, cnt);
	endtask
	task automatic wave(input string what, input int p, input int h);
		settle(3 * p + 20);
		chk({what, " period"}, p, period);
		chk({what, " high"}, h, high);
	endtask
	task automatic flat(input string what, input logic lvl);
		settle(1100);
		e0 = edges;
		settle(1100);
		chk({what, " edges"}, e0, edges);
		chk({what, " level"}, lvl, pin);
	endtask

	initial begin
		settle(5);
		i_nrst = 1'b1;
		settle(1);
		chk("reset state", 32'h0, {cnt, cmp, ovf, cmf, pin});
		// normal mode, stopped count, overflow flag
		setup(MODE_NORMAL, ACT_NONE, SEL_STOP);
		strobe(0, 8'hfd);
		settle(20);
		chk("stopped count", 8'hfd, cnt);
		setup(MODE_NORMAL, ACT_NONE, SEL_DIV1);
		wait_count(8'hff);
		settle(3);
		chk("overflow set", 1'b1, ovf);
		chk("wrapped low", 1'b1, cnt < 8'h05);
		settle(200);
		chk("overflow sticky", 1'b1, ovf);
		strobe(2, 8'h00);
		chk("overflow cleared", 1'b0, ovf);
		for (int s = 1; s < 8; s++) begin
			setup(MODE_NORMAL, ACT_NONE, 3'(s));
			strobe(0, 8'h00);
			wait_count(8'h02);
			n = 0;
			while (cnt === 8'h02 && n < 2000) begin
				@(negedge i_clk_sys);
				n++;
			end
			chk("tick spacing", divs[s], n);
		end
		$display("test normal and prescale done");
		// clear on compare
		setup(MODE_CLEAR_ON_COMPARE, ACT_TOGGLE, SEL_DIV1);
		strobe(1, 8'h09);
		chk("direct compare", 8'h09, cmp);
		wave("ctc toggle", 20, 10);
		e0 = 0;
		repeat (40) begin
			@(negedge i_clk_sys);
			if (int'(cnt) > e0) e0 = int'(cnt);
		end
		chk("ctc top", 9, e0);
		chk("compare flag", 1'b1, cmf);
		setup(MODE_CLEAR_ON_COMPARE, ACT_TOGGLE, SEL_STOP);
		strobe(3, 8'h00);
		settle(1);
		chk("compare flag cleared", 1'b0, cmf);
		strobe(2, 8'h00);
		strobe(0, 8'h08);
		strobe(1, 8'h05);
		setup(MODE_CLEAR_ON_COMPARE, ACT_TOGGLE, SEL_DIV1);
		wait_count(8'hff);
		settle(3);
		chk("ctc overflow", 1'b1, ovf);
		$display("test clear on compare done");
		// fast pwm
		strobe(2, 8'h00);
		setup(MODE_FAST_PWM, ACT_CLEAR, SEL_STOP);
		strobe(1, 8'h3f);
		chk("buffered compare", 8'h05, cmp);
		setup(MODE_FAST_PWM, ACT_CLEAR, SEL_DIV1);
		wave("fast", 256, 64);
		chk("fast active compare", 8'h3f, cmp);
		chk("fast overflow", 1'b1, ovf);
		wait_count(8'hff);
		settle(1);
		chk("fast restart", 8'h00, cnt);
		setup(MODE_FAST_PWM, ACT_SET, SEL_DIV1);
		wave("fast inverted", 256, 192);
		setup(MODE_FAST_PWM, ACT_TOGGLE, SEL_DIV1);
		wave("fast toggle", 512, 256);
		setup(MODE_FAST_PWM, ACT_CLEAR, SEL_DIV1);
		strobe(1, 8'h00);
		wave("fast spike", 256, 1);
		strobe(1, 8'hff);
		flat("fast max", 1'b1);
		$display("test fast pwm done");
		// phase correct pwm
		setup(MODE_PHASE_PWM, ACT_CLEAR, SEL_DIV1);
		strobe(1, 8'h40);
		wave("phase leaving max", 510, 128);
		setup(MODE_PHASE_PWM, ACT_SET, SEL_DIV1);
		wave("phase inverted", 510, 382);
		strobe(2, 8'h00);
		settle(520);
		chk("phase overflow", 1'b1, ovf);
		wait_count(8'hff);
		settle(1);
		chk("phase turn", 8'hfe, cnt);
		setup(MODE_PHASE_PWM, ACT_CLEAR, SEL_DIV1);
		strobe(1, 8'h00);
		flat("phase zero", 1'b0);
		strobe(1, 8'hff);
		flat("phase max", 1'b1);
		$display("test phase pwm done");
		finish_test();
	end
endmodule
